/* include/fpu_decode_pkg.sv */
// Opcodes, operation codes, cycle budgets and stack constants for the store/subtract decoder
package fpu_decode_pkg;

  // ************************************************
  // Opcode bytes
  // ************************************************
  localparam logic [7:0] OPC_D8 = 8'hD8;
  localparam logic [7:0] OPC_D9 = 8'hD9;
  localparam logic [7:0] OPC_DA = 8'hDA;
  localparam logic [7:0] OPC_DB = 8'hDB;
  localparam logic [7:0] OPC_DC = 8'hDC;
  localparam logic [7:0] OPC_DD = 8'hDD;
  localparam logic [7:0] OPC_DE = 8'hDE;
  localparam logic [7:0] OPC_DF = 8'hDF;
  localparam logic [7:0] OPC_WAIT = 8'h9B;
  localparam logic [7:0] MODRM_AX = 8'hE0;
  localparam logic [7:0] MODRM_TST = 8'hE4;
  localparam logic [7:0] MODRM_XAM = 8'hE5;
  localparam logic [7:0] MODRM_UCPP = 8'hE9;
  localparam logic [7:0] MODRM_LOG = 8'hF1;
  localparam logic [7:0] MODRM_XTR = 8'hF4;
  localparam logic [7:0] MODRM_LOGP1 = 8'hF9;
  localparam logic [4:0] REG_STP = 5'h1B;
  localparam logic [4:0] REG_SUB_LO = 5'h1C;
  localparam logic [4:0] REG_SUB_HI = 5'h1D;
  localparam logic [4:0] REG_XCH = 5'h19;

  // ************************************************
  // Operation codes
  // ************************************************
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_STORE_POP_REAL_REG = 5'h01,
    OP_STORE_POP_REAL_MEM = 5'h02,
    OP_STORE_POP_BCD = 5'h03,
    OP_STORE_INT = 5'h04,
    OP_STORE_POP_INT = 5'h05,
    OP_STORE_CW = 5'h06,
    OP_STORE_ENV = 5'h07,
    OP_STORE_SW_MEM = 5'h08,
    OP_STORE_SW_AX = 5'h09,
    OP_SUB_REG_TOP = 5'h0A,
    OP_SUB_TOP_REG = 5'h0B,
    OP_SUB_MEM_REAL = 5'h0C,
    OP_SUBR_MEM_REAL = 5'h0D,
    OP_SUB_MEM_INT = 5'h0E,
    OP_SUBR_MEM_INT = 5'h0F,
    OP_TEST_TOP = 5'h10,
    OP_UCOMPARE = 5'h11,
    OP_CLASSIFY = 5'h12,
    OP_EXCHANGE = 5'h13,
    OP_EXTRACT = 5'h14,
    OP_LOG = 5'h15,
    OP_LOG_P1 = 5'h16,
    OP_WAIT = 5'h17
  } fpu_op_e;

  // ************************************************
  // Cycle budgets (upper bounds)
  // ************************************************
  localparam logic [7:0] CYC_STORE_REAL = 8'd2;
  localparam logic [7:0] CYC_BCD = 8'd63;
  localparam logic [7:0] CYC_INT32 = 8'd13;
  localparam logic [7:0] CYC_INT16 = 8'd10;
  localparam logic [7:0] CYC_INT64 = 8'd13;
  localparam logic [7:0] CYC_CW_WAIT = 8'd5;
  localparam logic [7:0] CYC_CW_NOWAIT = 8'd3;
  localparam logic [7:0] CYC_ENV_WAIT = 8'd24;
  localparam logic [7:0] CYC_ENV_NOWAIT = 8'd22;
  localparam logic [7:0] CYC_SW_WAIT = 8'd6;
  localparam logic [7:0] CYC_SW_NOWAIT = 8'd4;
  localparam logic [7:0] CYC_AX_WAIT = 8'd4;
  localparam logic [7:0] CYC_AX_NOWAIT = 8'd2;
  localparam logic [7:0] CYC_SUB = 8'd9;
  localparam logic [7:0] CYC_ISUB32 = 8'd29;
  localparam logic [7:0] CYC_ISUB16 = 8'd27;
  localparam logic [7:0] CYC_CMP = 8'd4;
  localparam logic [7:0] CYC_WAIT = 8'd2;
  localparam logic [7:0] CYC_XCH = 8'd3;
  localparam logic [7:0] CYC_EXTRACT = 8'd16;
  localparam logic [7:0] CYC_LOG = 8'd154;
  localparam logic [7:0] CYC_LOG_P1 = 8'd133;
  localparam logic [7:0] CYC_LOG_P1_OOR = 8'd170;

  localparam logic [2:0] TOP_RESET = 3'h0;
endpackage

/* src/fpu_op_decode.sv */
// Combinational opcode/modrm to operation, stack effect and cycle budget table
`timescale 1ns/1ps
module fpu_op_decode
  import fpu_decode_pkg::*;
(
  input wire logic [7:0] opcode,
  input wire logic [7:0] modrm,
  input wire logic wait_prefix,
  output fpu_decode_pkg::fpu_op_e op,
  output logic [2:0] reg_n,
  output logic [1:0] pops,
  output logic push,
  output logic result_to_reg,
  output logic [7:0] budget,
  output logic size_code_valid
);
  logic is_reg;
  logic [2:0] rf;

  assign is_reg = (modrm[7:6] == 2'b11);
  assign rf = modrm[5:3];
  assign reg_n = modrm[2:0];

  always_comb begin
    op = OP_NONE;
    pops = 2'd0;
    push = 1'b0;
    result_to_reg = 1'b0;
    budget = 8'd0;
    unique case (opcode)
      OPC_D8: begin
        if (is_reg && modrm[7:4] == 4'hE) begin
          // Always top minus register; bit 3 only picks where the result lands
          op = OP_SUB_TOP_REG;
          result_to_reg = modrm[3]; // [RULE9] [RULE12]
          budget = CYC_SUB;
        end else if (!is_reg && rf == 3'd4) begin
          op = OP_SUB_MEM_REAL; // [RULE10]
          budget = CYC_SUB;
        end
      end
      OPC_D9: begin
        if (modrm == MODRM_TST) begin
          op = OP_TEST_TOP; // [RULE16]
          budget = CYC_CMP;
        end else if (modrm == MODRM_XAM) begin
          op = OP_CLASSIFY; // [RULE20]
          budget = CYC_CMP;
        end else if (modrm == MODRM_XTR) begin
          op = OP_EXTRACT; // [RULE21]
          push = 1'b1;
          budget = CYC_EXTRACT;
        end else if (modrm == MODRM_LOG) begin
          op = OP_LOG; // [RULE22]
          pops = 2'd1;
          budget = CYC_LOG;
        end else if (modrm == MODRM_LOGP1) begin
          op = OP_LOG_P1; // [RULE22]
          pops = 2'd1;
          budget = CYC_LOG_P1;
        end else if (modrm[7:3] == REG_XCH) begin
          op = OP_EXCHANGE; // [RULE20]
          budget = CYC_XCH;
        end else if (!is_reg && rf == 3'd3) begin
          op = OP_STORE_POP_REAL_MEM; // [RULE2]
          pops = 2'd1;
          budget = CYC_STORE_REAL;
        end else if (!is_reg && rf == 3'd7) begin
          op = OP_STORE_CW; // [RULE6]
          budget = wait_prefix ? CYC_CW_WAIT : CYC_CW_NOWAIT;
        end else if (!is_reg && rf == 3'd6) begin
          op = OP_STORE_ENV; // [RULE7]
          budget = wait_prefix ? CYC_ENV_WAIT : CYC_ENV_NOWAIT;
        end
      end
      OPC_DA: begin
        if (modrm == MODRM_UCPP) begin
          op = OP_UCOMPARE; // [RULE18]
          pops = 2'd2;
          budget = CYC_CMP;
        end else if (!is_reg && (rf == 3'd4 || rf == 3'd5)) begin
          op = (rf == 3'd4) ? OP_SUB_MEM_INT : OP_SUBR_MEM_INT; // [RULE14] [RULE15]
          budget = CYC_ISUB32;
        end
      end
      OPC_DB: begin
        if (modrm[7:3] == REG_STP) begin
          op = OP_STORE_POP_REAL_REG; // [RULE1]
          pops = 2'd1;
          result_to_reg = 1'b1;
          budget = CYC_STORE_REAL;
        end else if (!is_reg && rf == 3'd7) begin
          op = OP_STORE_POP_REAL_MEM; // [RULE2]
          pops = 2'd1;
          budget = CYC_STORE_REAL;
        end else if (!is_reg && rf == 3'd2) begin
          op = OP_STORE_INT; // [RULE4]
          budget = CYC_INT32;
        end else if (!is_reg && rf == 3'd3) begin
          op = OP_STORE_POP_INT; // [RULE5]
          pops = 2'd1;
          budget = CYC_INT32;
        end
      end
      OPC_DC: begin
        if (is_reg && modrm[7:4] == 4'hE) begin
          // Always register minus top; bit 3 only picks where the result lands
          op = OP_SUB_REG_TOP;
          result_to_reg = modrm[3]; // [RULE9] [RULE12]
          budget = CYC_SUB;
        end else if (!is_reg && (rf == 3'd4 || rf == 3'd5)) begin
          op = (rf == 3'd4) ? OP_SUB_MEM_REAL : OP_SUBR_MEM_REAL; // [RULE10] [RULE12]
          budget = CYC_SUB;
        end
      end
      OPC_DD: begin
        if (is_reg && modrm[7:4] == 4'hE) begin
          op = OP_UCOMPARE; // [RULE17]
          pops = modrm[3] ? 2'd1 : 2'd0;
          budget = CYC_CMP;
        end else if (!is_reg && rf == 3'd3) begin
          op = OP_STORE_POP_REAL_MEM; // [RULE2]
          pops = 2'd1;
          budget = CYC_STORE_REAL;
        end else if (!is_reg && rf == 3'd7) begin
          op = OP_STORE_SW_MEM; // [RULE8]
          budget = wait_prefix ? CYC_SW_WAIT : CYC_SW_NOWAIT;
        end
      end
      OPC_DE: begin
        if (is_reg && modrm[7:4] == 4'hE) begin
          // 1 n: reg minus top; 0 n: top minus reg; both land in reg then pop
          op = modrm[3] ? OP_SUB_REG_TOP : OP_SUB_TOP_REG; // [RULE11] [RULE13]
          result_to_reg = 1'b1;
          pops = 2'd1;
          budget = CYC_SUB;
        end else if (!is_reg && (rf == 3'd4 || rf == 3'd5)) begin
          op = (rf == 3'd4) ? OP_SUB_MEM_INT : OP_SUBR_MEM_INT; // [RULE14] [RULE15]
          budget = CYC_ISUB16;
        end
      end
      OPC_DF: begin
        if (modrm == MODRM_AX) begin
          op = OP_STORE_SW_AX; // [RULE8]
          budget = wait_prefix ? CYC_AX_WAIT : CYC_AX_NOWAIT;
        end else if (!is_reg && rf == 3'd6) begin
          op = OP_STORE_POP_BCD; // [RULE3]
          pops = 2'd1;
          budget = CYC_BCD;
        end else if (!is_reg && rf == 3'd2) begin
          op = OP_STORE_INT; // [RULE4]
          budget = CYC_INT16;
        end else if (!is_reg && (rf == 3'd7 || rf == 3'd3)) begin
          op = OP_STORE_POP_INT; // [RULE5]
          pops = 2'd1;
          budget = (rf == 3'd7) ? CYC_INT64 : CYC_INT16;
        end
      end
      default: begin
        op = OP_NONE;
      end
    endcase
  end

  assign size_code_valid = (op != OP_NONE);
endmodule // fpu_op_decode

/* src/fpu_store_sub_compare_decode.sv */
// Sequencer for the store, subtract, compare and misc floating-point instruction group
// What this block does
// RULE1: DB 11011n copies top to reg, pops, 2.
// RULE2: Real memory stores with pop, 2 cycles.
// RULE3: DF reg 110 packed decimal store, pop.
// RULE4: Integer store without pop, 13/10 cycles.
// RULE5: Integer store with pop, 13/13/10 cycles.
// RULE6: Control word store, 5 waiting, 3 not.
// RULE7: Environment store, 24 waiting, 22 not.
// RULE8: Status word store to memory or accumulator.
// RULE9: Register subtract forms, 9 cycles.
// RULE10: Memory real subtract into top, 9 cycles.
// RULE11: DE 11101n reg minus top, then pop.
// RULE12: Reverse subtract register and memory forms.
// RULE13: DE 11100n top minus reg, then pop.
// RULE14: Memory integer subtract, 29 or 27 cycles.
// RULE15: Reverse memory integer subtract, 29/27 cycles.
// RULE16: D9 E4 tests top, 4 cycles.
// RULE17: DD 1110xn unordered compare, optional pop.
// RULE18: DA E9 compare then pop two.
// RULE19: 9B waits until idle, at least 2.
// RULE20: Classify top 4; exchange 3 cycles.
// RULE21: D9 F4 extract exponent, push, 16.
// RULE22: Log multiply forms, result in reg1, pop.
// RULE23: Pop increments top, push decrements top.
// RULE24: Log plus one out of range: 170.
// RULE25: Budget is the range upper bound.
`timescale 1ns/1ps
module fpu_store_sub_compare_decode
  import fpu_decode_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire logic [7:0] issue_opcode,
  input wire logic [7:0] issue_modrm,
  input wire logic issue_wait_prefix,
  input wire logic operand_out_of_range,
  input wire logic unit_busy,
  output logic issue_ready,
  output logic busy,
  output logic done,
  output logic illegal,
  output fpu_decode_pkg::fpu_op_e active_op,
  output logic [2:0] active_reg,
  output logic result_to_reg,
  output logic [7:0] cycle_budget,
  output logic [2:0] stack_top
);

  // ************************************************
  // Decode
  // ************************************************
  fpu_op_e dec_op;
  logic [2:0] dec_reg;
  logic [1:0] dec_pops;
  logic dec_push;
  logic dec_to_reg;
  logic [7:0] dec_budget;
  logic dec_valid;
  logic is_wait;

  fpu_op_decode u_decode (
    .opcode(issue_opcode),
    .modrm(issue_modrm),
    .wait_prefix(issue_wait_prefix),
    .op(dec_op),
    .reg_n(dec_reg),
    .pops(dec_pops),
    .push(dec_push),
    .result_to_reg(dec_to_reg),
    .budget(dec_budget),
    .size_code_valid(dec_valid)
  );

  assign is_wait = (issue_opcode == OPC_WAIT);

  // ************************************************
  // Sequencer
  // ************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PREWAIT = 2'b01,
    ST_EXEC = 2'b10
  } seq_state_e;

  seq_state_e state_reg;
  logic [7:0] count_reg;
  logic [1:0] pops_reg;
  logic push_reg;
  logic prefix_wait;
  logic take;

  assign take = issue_valid && (state_reg == ST_IDLE);
  // Only the store-state forms wait; a prefix on a two-cycle store would
  // leave nothing to count after the prewait cycle and hang the sequencer
  assign prefix_wait = issue_wait_prefix &&
                       (dec_op inside {OP_STORE_CW, OP_STORE_ENV, OP_STORE_SW_MEM, OP_STORE_SW_AX});

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take && is_wait) begin
            state_reg <= ST_PREWAIT; // [RULE19]
          end else if (take && dec_valid && prefix_wait) begin
            state_reg <= ST_PREWAIT; // [RULE6] [RULE7] [RULE8]
          end else if (take && dec_valid) begin
            state_reg <= ST_EXEC;
          end
        end
        ST_PREWAIT: begin
          // Waits until the other unit drains; this state is the one-cycle minimum
          if (!unit_busy) begin
            state_reg <= (active_op == OP_WAIT) ? ST_IDLE : ST_EXEC; // [RULE19]
          end
        end
        ST_EXEC: begin
          if (count_reg == 8'd1) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // Captured instruction
  // ************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_op <= OP_NONE;
      active_reg <= 3'd0;
      result_to_reg <= 1'b0;
      cycle_budget <= 8'd0;
      pops_reg <= 2'd0;
      push_reg <= 1'b0;
    end else if (take && is_wait) begin
      active_op <= OP_WAIT;
      active_reg <= 3'd0;
      result_to_reg <= 1'b0;
      cycle_budget <= CYC_WAIT; // [RULE19]
      pops_reg <= 2'd0;
      push_reg <= 1'b0;
    end else if (take && dec_valid) begin
      active_op <= dec_op;
      // Log forms always target register one
      active_reg <= (dec_op == OP_LOG || dec_op == OP_LOG_P1) ? 3'd1 : dec_reg; // [RULE22]
      result_to_reg <= dec_to_reg || dec_op == OP_LOG || dec_op == OP_LOG_P1;
      if (dec_op == OP_LOG_P1 && operand_out_of_range) begin
        cycle_budget <= CYC_LOG_P1_OOR; // [RULE24]
      end else begin
        cycle_budget <= dec_budget; // [RULE25]
      end
      pops_reg <= dec_pops;
      push_reg <= dec_push;
    end
  end

  // ************************************************
  // Cycle counter
  // ************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= 8'd0;
    end else if (take && dec_valid && !is_wait && !prefix_wait) begin
      // Count includes the issue cycle
      if (dec_op == OP_LOG_P1 && operand_out_of_range) begin
        count_reg <= CYC_LOG_P1_OOR - 8'd1; // [RULE24]
      end else begin
        count_reg <= dec_budget - 8'd1; // [RULE25]
      end
    end else if (state_reg == ST_PREWAIT && !unit_busy) begin
      // Prewait already spent one cycle; two wait cycles are inside the budget
      count_reg <= cycle_budget - 8'd2; // [RULE6] [RULE7] [RULE8]
    end else if (state_reg == ST_EXEC && count_reg != 8'd0) begin
      count_reg <= count_reg - 8'd1;
    end
  end

  // ************************************************
  // Stack pointer
  // ************************************************
  logic finish;
  assign finish = (state_reg == ST_EXEC && count_reg == 8'd1) ||
                  (state_reg == ST_PREWAIT && !unit_busy && active_op == OP_WAIT);

  // References use the pointer as it stood before the instruction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_top <= TOP_RESET;
    end else if (finish && state_reg == ST_EXEC) begin
      stack_top <= stack_top + {1'b0, pops_reg} - {2'b00, push_reg}; // [RULE23]
    end
  end

  // ************************************************
  // Handshake outputs
  // ************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      issue_ready <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      busy <= (state_reg != ST_IDLE && !finish) || (take && (dec_valid || is_wait));
      issue_ready <= (state_reg == ST_IDLE && !take) || finish;
      done <= finish;
      illegal <= take && !dec_valid && !is_wait;
    end
  end

endmodule // fpu_store_sub_compare_decode

/* verification/int_unit_model.sv */
// Integer unit model that offers floating-point instructions
`timescale 1ns/1ps
module int_unit_model (
  input wire logic clk,
  input wire logic issue_ready,
  output logic issue_valid,
  output logic [7:0] issue_opcode,
  output logic [7:0] issue_modrm,
  output logic issue_wait_prefix,
  output logic operand_out_of_range
);
  initial begin
    issue_valid = 1'b0;
    issue_opcode = 8'h00;
    issue_modrm = 8'h00;
    issue_wait_prefix = 1'b0;
    operand_out_of_range = 1'b0;
  end

  // Called at a falling edge; returns at the falling edge after the take
  task automatic offer(input logic [7:0] opc, input logic [7:0] mr, input logic pf,
      input logic oor);
    issue_opcode = opc;
    issue_modrm = mr;
    issue_wait_prefix = pf;
    operand_out_of_range = oor;
    issue_valid = 1'b1;
    do @(posedge clk); while (issue_ready !== 1'b1);
    @(negedge clk);
    issue_valid = 1'b0;
    // Released lines show the inverse so a stale copy is never mistaken for data
    issue_opcode = ~opc;
    issue_modrm = ~mr;
    issue_wait_prefix = ~pf;
    operand_out_of_range = ~oor;
  endtask
endmodule // int_unit_model

/* verification/fpu_decode_properties.sv */
// Concurrent checks on the decoder's outputs
`timescale 1ns/1ps
module fpu_decode_properties
  import fpu_decode_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic busy,
  input wire logic done,
  input fpu_decode_pkg::fpu_op_e active_op,
  input wire logic [2:0] active_reg,
  input wire logic result_to_reg,
  input wire logic [7:0] cycle_budget,
  input wire logic [2:0] stack_top
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_real_store_time: assert property (
    $rose(busy) && active_op inside {OP_STORE_POP_REAL_REG, OP_STORE_POP_REAL_MEM} |-> ##1 done)
    else $error("real store not done after 2 cycles");
  a_compare_time: assert property (
    $rose(busy) && active_op inside {OP_TEST_TOP, OP_UCOMPARE, OP_CLASSIFY}
    |-> !done [*3] ##1 done) else $error("compare or classify not done after 4 cycles");
  a_exchange_time: assert property (
    $rose(busy) && active_op == OP_EXCHANGE |-> !done [*2] ##1 done)
    else $error("exchange not done after 3 cycles");
  a_bcd_budget: assert property (
    busy && active_op == OP_STORE_POP_BCD |-> cycle_budget == 8'h3F)
    else $error("packed store budget wrong");
  a_sub_budget: assert property (
    busy && active_op inside {OP_SUB_REG_TOP, OP_SUB_TOP_REG, OP_SUB_MEM_REAL, OP_SUBR_MEM_REAL}
    |-> cycle_budget == 8'h09) else $error("subtract budget wrong");
  a_isub_budget: assert property (
    busy && active_op inside {OP_SUB_MEM_INT, OP_SUBR_MEM_INT}
    |-> cycle_budget inside {8'h1B, 8'h1D}) else $error("integer subtract budget wrong");
  a_int_no_pop: assert property (
    done && active_op == OP_STORE_INT |-> $stable(stack_top))
    else $error("integer store moved the stack");
  a_extract_push: assert property (
    done && active_op == OP_EXTRACT |-> stack_top == $past(stack_top) - 3'h1)
    else $error("extract did not push");
  a_log_target: assert property (
    busy && active_op inside {OP_LOG, OP_LOG_P1} |-> active_reg == 3'h1 && result_to_reg)
    else $error("log result not aimed at register 1");
  a_log_pop: assert property (
    done && active_op inside {OP_LOG, OP_LOG_P1} |-> stack_top == $past(stack_top) + 3'h1)
    else $error("log did not pop");
  a_log_p1_budget: assert property (
    busy && active_op == OP_LOG_P1 |-> cycle_budget inside {8'h85, 8'hAA})
    else $error("log plus one budget wrong");
endmodule // fpu_decode_properties

bind fpu_store_sub_compare_decode fpu_decode_properties u_props (
  .clk(clk),
  .rst_n(rst_n),
  .busy(busy),
  .done(done),
  .active_op(active_op),
  .active_reg(active_reg),
  .result_to_reg(result_to_reg),
  .cycle_budget(cycle_budget),
  .stack_top(stack_top)
);

/* verification/tb.sv */
// Self-checking bench for the store, subtract and compare decoder
`timescale 1ns/1ps
module tb;
  import fpu_decode_pkg::*;
  typedef struct {
    logic [7:0] opc;
    logic [7:0] mr;
    logic [1:0] fl;
    fpu_op_e op;
    logic [7:0] bud;
    logic [2:0] dlt;
    logic [2:0] rn;
    logic [1:0] msk;
  } row_s;
  logic clk, rst_n, unit_busy, issue_valid, issue_wait_prefix, operand_out_of_range;
  logic issue_ready, busy, done, illegal, result_to_reg;
  logic [7:0] issue_opcode, issue_modrm, cycle_budget;
  logic [2:0] active_reg, stack_top;
  fpu_op_e active_op;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  row_s rows[$];

  fpu_store_sub_compare_decode dut (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue_opcode(issue_opcode), .issue_modrm(issue_modrm),
    .issue_wait_prefix(issue_wait_prefix), .operand_out_of_range(operand_out_of_range),
    .unit_busy(unit_busy), .issue_ready(issue_ready), .busy(busy), .done(done),
    .illegal(illegal), .active_op(active_op), .active_reg(active_reg),
    .result_to_reg(result_to_reg), .cycle_budget(cycle_budget), .stack_top(stack_top));
  int_unit_model iu (.clk(clk), .issue_ready(issue_ready), .issue_valid(issue_valid),
    .issue_opcode(issue_opcode), .issue_modrm(issue_modrm),
    .issue_wait_prefix(issue_wait_prefix), .operand_out_of_range(operand_out_of_range));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************
  // Helpers
  // ****************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic void add(input logic [7:0] opc, input logic [7:0] mr, input logic [1:0] fl,
      input fpu_op_e op, input logic [7:0] bud, input logic [2:0] dlt, input logic [2:0] rn,
      input logic [1:0] msk);
    rows.push_back('{opc, mr, fl, op, bud, dlt, rn, msk});
  endfunction

  // Offer one instruction straight after the previous done, so issue is back-to-back
  task automatic run(input row_s r);
    logic [2:0] top0;
    top0 = stack_top;
    iu.offer(r.opc, r.mr, r.fl[1], r.fl[0]);
    n = 1;
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("cycles", n[7:0], r.bud);
    check("budget", cycle_budget, r.bud);
    check("op", active_op, r.op);
    check("stack", stack_top, 3'(top0 + r.dlt));
    if (r.msk[1]) check("reg", active_reg, r.rn);
    if (r.msk[0]) check("to_reg", result_to_reg, r.msk[1] & r.rn[0] | r.dlt[2]);
    $display("test %0h %0h ended", r.opc, r.mr);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    rst_n = 1'b0;
    unit_busy = 1'b0;
    add(8'hDB,8'hDB,2'h0,OP_STORE_POP_REAL_REG,8'h02,3'h1,3'h3,2'h2);
    add(8'hDB,8'h38,2'h0,OP_STORE_POP_REAL_MEM,8'h02,3'h1,3'h0,2'h0);
    add(8'hDD,8'h18,2'h0,OP_STORE_POP_REAL_MEM,8'h02,3'h1,3'h0,2'h0);
    add(8'hD9,8'h18,2'h0,OP_STORE_POP_REAL_MEM,8'h02,3'h1,3'h0,2'h0);
    add(8'hDF,8'h30,2'h0,OP_STORE_POP_BCD,8'h3F,3'h1,3'h0,2'h0);
    add(8'hDB,8'h10,2'h0,OP_STORE_INT,8'h0D,3'h0,3'h0,2'h0);
    add(8'hDF,8'h10,2'h0,OP_STORE_INT,8'h0A,3'h0,3'h0,2'h0);
    add(8'hDF,8'h38,2'h0,OP_STORE_POP_INT,8'h0D,3'h1,3'h0,2'h0);
    add(8'hDB,8'h18,2'h0,OP_STORE_POP_INT,8'h0D,3'h1,3'h0,2'h0);
    add(8'hDF,8'h18,2'h0,OP_STORE_POP_INT,8'h0A,3'h1,3'h0,2'h0);
    add(8'hD9,8'h38,2'h2,OP_STORE_CW,8'h05,3'h0,3'h0,2'h0);
    add(8'hD9,8'h38,2'h0,OP_STORE_CW,8'h03,3'h0,3'h0,2'h0);
    add(8'hD9,8'h30,2'h2,OP_STORE_ENV,8'h18,3'h0,3'h0,2'h0);
    add(8'hD9,8'h30,2'h0,OP_STORE_ENV,8'h16,3'h0,3'h0,2'h0);
    add(8'hDD,8'h38,2'h2,OP_STORE_SW_MEM,8'h06,3'h0,3'h0,2'h0);
    add(8'hDD,8'h38,2'h0,OP_STORE_SW_MEM,8'h04,3'h0,3'h0,2'h0);
    add(8'hDF,8'hE0,2'h2,OP_STORE_SW_AX,8'h04,3'h0,3'h0,2'h0);
    add(8'hDF,8'hE0,2'h0,OP_STORE_SW_AX,8'h02,3'h0,3'h0,2'h0);
    add(8'hDC,8'hEB,2'h0,OP_SUB_REG_TOP,8'h09,3'h0,3'h3,2'h3);
    add(8'hD8,8'hE4,2'h0,OP_SUB_TOP_REG,8'h09,3'h0,3'h4,2'h3);
    add(8'hDE,8'hE9,2'h0,OP_SUB_REG_TOP,8'h09,3'h1,3'h1,2'h3);
    add(8'hDE,8'hE5,2'h0,OP_SUB_TOP_REG,8'h09,3'h1,3'h5,2'h3);
    add(8'hDC,8'hE2,2'h0,OP_SUB_REG_TOP,8'h09,3'h0,3'h2,2'h3);
    add(8'hD8,8'hEF,2'h0,OP_SUB_TOP_REG,8'h09,3'h0,3'h7,2'h3);
    add(8'hDC,8'h20,2'h0,OP_SUB_MEM_REAL,8'h09,3'h0,3'h0,2'h1);
    add(8'hD8,8'h20,2'h0,OP_SUB_MEM_REAL,8'h09,3'h0,3'h0,2'h1);
    add(8'hDC,8'h28,2'h0,OP_SUBR_MEM_REAL,8'h09,3'h0,3'h0,2'h1);
    add(8'hDA,8'h20,2'h0,OP_SUB_MEM_INT,8'h1D,3'h0,3'h0,2'h1);
    add(8'hDE,8'h20,2'h0,OP_SUB_MEM_INT,8'h1B,3'h0,3'h0,2'h1);
    add(8'hDA,8'h28,2'h0,OP_SUBR_MEM_INT,8'h1D,3'h0,3'h0,2'h1);
    add(8'hDE,8'h28,2'h0,OP_SUBR_MEM_INT,8'h1B,3'h0,3'h0,2'h1);
    add(8'hD9,8'hE4,2'h0,OP_TEST_TOP,8'h04,3'h0,3'h0,2'h0);
    add(8'hDD,8'hE2,2'h0,OP_UCOMPARE,8'h04,3'h0,3'h2,2'h2);
    add(8'hDD,8'hEF,2'h0,OP_UCOMPARE,8'h04,3'h1,3'h7,2'h2);
    add(8'hDA,8'hE9,2'h0,OP_UCOMPARE,8'h04,3'h2,3'h1,2'h2);
    add(8'hD9,8'hE5,2'h0,OP_CLASSIFY,8'h04,3'h0,3'h0,2'h0);
    add(8'hD9,8'hCB,2'h0,OP_EXCHANGE,8'h03,3'h0,3'h3,2'h2);
    add(8'hD9,8'hF4,2'h0,OP_EXTRACT,8'h10,3'h7,3'h0,2'h0);
    add(8'hD9,8'hF1,2'h0,OP_LOG,8'h9A,3'h1,3'h1,2'h2);
    add(8'hD9,8'hF9,2'h0,OP_LOG_P1,8'h85,3'h1,3'h1,2'h2);
    add(8'hD9,8'hF9,2'h1,OP_LOG_P1,8'hAA,3'h1,3'h1,2'h2);
    add(8'h9B,8'h00,2'h0,OP_WAIT,8'h02,3'h0,3'h0,2'h0);
    repeat (20) @(negedge clk);
    check("rst_top", stack_top, TOP_RESET);
    check("rst_op", active_op, OP_NONE);
    check("rst_busy", {busy, done, illegal, issue_ready}, 8'h00);
    rst_n = 1'b1;
    @(negedge clk);
    check("ready", issue_ready, 1'b1);
    $display("test reset ended");
    foreach (rows[i]) run(rows[i]);
    // Unknown and reserved codes: pulse only, stack untouched
    for (int k = 0; k < 2; k++) begin
      n = stack_top;
      iu.offer(k ? 8'hD9 : 8'h00, k ? 8'hD7 : 8'h00, 1'b0, 1'b0);
      check("illegal", {illegal, busy}, 8'h02);
      check("ill_stack", stack_top, n[2:0]);
      @(negedge clk);
    end
    $display("test illegal ended");
    // Wait forms hold while the unit is busy
    for (int k = 0; k < 2; k++) begin
      unit_busy = 1'b1;
      iu.offer(k ? 8'hD9 : 8'h9B, 8'h38, k[0], 1'b0);
      repeat (4) begin
        check("early_done", done, 1'b0);
        @(negedge clk);
      end
      unit_busy = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      check("wait_tail", n <= (k ? 5 : 2), 1'b1);
    end
    $display("test wait ended");
    // Reset in the middle of a long log evaluation
    iu.offer(8'hD9, 8'hF1, 1'b0, 1'b0);
    repeat (10) @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    check("mid_top", stack_top, TOP_RESET);
    check("mid_state", {busy, done}, 8'h00);
    rst_n = 1'b1;
    @(negedge clk);
    run(rows[0]);
    $display("test mid reset ended");
    report_and_stop();
  end
endmodule // tb
